/* include/res_ext_defines.svh */
`ifndef RES_EXT_DEFINES_SVH
`define RES_EXT_DEFINES_SVH
`define DIV_MIN      4'h8
`define DIV_MAX      4'hF
`define DIV_RESET    4'h8
`define WGT_RESET    4'h8
`define WGT_BIT8     3
`define WGT_BIT4     2
`define WGT_BIT2     1
`define WGT_BIT1     0
`define SHIFT_W8     3'h0
`define SHIFT_W4     3'h1
`define SHIFT_W2     3'h2
`define SHIFT_W1     3'h3
`define LIN_EXTRA    3'h2
`define PM_EXTRA     3'h3
`define FRAC_BITS    3
`define FACT_RESET   7'h08
`define FACT_MIN     7'h08
`define FACT_MAX     7'h78
`define RSHIFT_RESET 7'h02
`define RDIV_RESET   7'h08
`define OFF_CTRL     32'h0000_0000
`define OFF_SEL      32'h0000_0004
`define OFF_ACT      32'h0000_0008
`define OFF_FACT     32'h0000_000C
`define OFF_RES      32'h0000_0010
`define CTRL_REINIT  0
`define CTRL_MANUAL  1
`define CTRL_MIRROR  2
`endif

/* include/res_ext_pkg.sv */
package res_ext_pkg;
  typedef struct packed {
    logic [3:0] divisor;
    logic [3:0] weightX;
    logic [3:0] weightY;
  } ext_sel_t;
  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_SETTLE = 2'b10
  } load_state_t;
endpackage

/* rtl/axis_scale.sv */
`timescale 1ns/1ns
`include "res_ext_defines.svh"
module axis_scale
  import res_ext_pkg::*;
(
  // Setting
  input  wire logic [3:0] divisor,
  input  wire logic [3:0] weight,
  // Results, factor as 4.3 fixed point
  output      logic [6:0] factor,
  output      logic [2:0] weightShift,
  output      logic       weightValid
);
  function automatic logic [2:0] shift_of(input logic [3:0] w);
    case (w)
      4'h8:    shift_of = `SHIFT_W8;
      4'h4:    shift_of = `SHIFT_W4;
      4'h2:    shift_of = `SHIFT_W2;
      default: shift_of = `SHIFT_W1;
    endcase
  endfunction
  // Weights are powers of two, so divide is a shift
  assign weightShift = shift_of(weight);
  assign factor      = 7'({divisor, 3'h0} >> (`FRAC_BITS - weightShift));
  assign weightValid = $onehot(weight);
endmodule

/* rtl/resolution_extension_select.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "res_ext_defines.svh"
module resolution_extension_select
  import res_ext_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Switch settings
  input  wire ext_sel_t   selIn,
  // Backplane system reset, synchronous level
  input  wire logic       sysReset,
  // APB
  input  wire apb_req_t   apbReq,
  output      apb_rsp_t   apbRsp,
  // Active scaling per axis
  output      logic [6:0] factorX,
  output      logic [6:0] factorY,
  output      logic [6:0] resShiftX,
  output      logic [6:0] resShiftY,
  output      logic [6:0] resDivX,
  output      logic [6:0] resDivY,
  output      logic       selBad
);
  ext_sel_t   active;
  ext_sel_t   pending;
  logic       manualSw;
  logic       manualPrev;
  logic       mirror;
  logic [31:0] rdata;
  logic [31:0] rdataQ;
  logic       sysPrev;
  logic [6:0] next_factorX;
  logic [6:0] next_factorY;
  logic [2:0] shX;
  logic [2:0] shY;
  logic       okX;
  logic       okY;

  // One word per register, so the whole byte address is compared
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
    addr_hit = (a == off);
  endfunction
  // Optics term plus weight term, shared by both axes
  function automatic logic [6:0] res_shift(input logic [2:0] extra, input logic [2:0] sh);
    res_shift = {4'h0, extra} + {4'h0, sh};
  endfunction

  wire        apbSetup   = apbReq.psel & ~apbReq.penable;
  wire        apbWr      = apbReq.psel & apbReq.penable & apbReq.pwrite;
  wire        apbRd      = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
  wire        hitCtrl    = addr_hit(apbReq.paddr, `OFF_CTRL);
  wire        hitSel     = addr_hit(apbReq.paddr, `OFF_SEL);
  wire        hitAct     = addr_hit(apbReq.paddr, `OFF_ACT);
  wire        hitFact    = addr_hit(apbReq.paddr, `OFF_FACT);
  wire        hitRes     = addr_hit(apbReq.paddr, `OFF_RES);
  wire        hitAny     = hitCtrl | hitSel | hitAct | hitFact | hitRes;
  wire        reinitCmd  = apbWr & hitCtrl & apbReq.pwdata[`CTRL_REINIT];
  wire        manualNext = (apbWr & hitCtrl) ? apbReq.pwdata[`CTRL_MANUAL] : manualSw;
  // Raise then lower: act on the falling edge of the switch
  wire        manualFall = manualPrev & ~manualSw;
  wire        sysRise    = sysReset & ~sysPrev;
  wire        loadNow    = sysRise | manualFall | reinitCmd;
  wire        divOk      = pending.divisor >= `DIV_MIN;
  wire [2:0]  optExtra   = mirror ? `PM_EXTRA : `LIN_EXTRA;
  axis_scale uX (
    .divisor     (active.divisor),
    .weight      (active.weightX),
    .factor      (next_factorX),
    .weightShift (shX),
    .weightValid (okX)
  );
  axis_scale uY (
    .divisor     (active.divisor),
    .weight      (active.weightY),
    .factor      (next_factorY),
    .weightShift (shY),
    .weightValid (okY)
  );
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending <= '{`DIV_RESET, `WGT_RESET, `WGT_RESET};
    end else begin
      pending <= selIn;
    end
  end

  // Both edge detectors idle low like their sources, so reset makes no edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manualSw   <= 1'b0;
      manualPrev <= 1'b0;
    end else begin
      manualSw   <= manualNext;
      manualPrev <= manualSw;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sysPrev <= 1'b0;
    end else begin
      sysPrev <= sysReset;
    end
  end

  // Optics type applies at once; it does not alter the scaling factor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mirror <= 1'b0;
    end else if (apbWr && hitCtrl) begin
      mirror <= apbReq.pwdata[`CTRL_MIRROR];
    end
  end
  // Switch changes never reach the scaler between load events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= '{`DIV_RESET, `WGT_RESET, `WGT_RESET};
    end else if (loadNow) begin
      active <= pending;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      factorX   <= `FACT_RESET;
      resShiftX <= `RSHIFT_RESET;
      resDivX   <= `RDIV_RESET;
    end else begin
      factorX   <= next_factorX;
      // Resolution is lambda * 2^-shift * 8 / divisor
      resShiftX <= res_shift(optExtra, shX);
      resDivX   <= {3'h0, active.divisor};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      factorY   <= `FACT_RESET;
      resShiftY <= `RSHIFT_RESET;
      resDivY   <= `RDIV_RESET;
    end else begin
      factorY   <= next_factorY;
      resShiftY <= res_shift(optExtra, shY);
      resDivY   <= {3'h0, active.divisor};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selBad <= 1'b0;
    end else begin
      selBad <= ~okX | ~okY | (active.divisor < `DIV_MIN);
    end
  end
  assign rdata = hitCtrl ? {29'h0, mirror, manualSw, 1'b0}
               : hitSel  ? {19'h0, divOk, pending}
               : hitAct  ? {20'h0, active}
               : hitFact ? {18'h0, next_factorY, next_factorX}
               : hitRes  ? {18'h0, resShiftY, resShiftX}
               : 32'h0;

  // Read word is taken in the setup cycle, so bus data comes from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdataQ <= '0;
    end else if (apbSetup) begin
      rdataQ <= rdata;
    end
  end

  // Zero wait states: every access completes in its first access cycle
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = apbReq.psel & apbReq.penable & ~hitAny;
  assign apbRsp.prdata  = apbRd ? rdataQ : 32'h0;

  a_load_gate: assert property (@(posedge clk) disable iff (rst)
    !$past(loadNow) && $past(!rst) |-> $stable(active))
    else $error("active setting changed without load event");
  a_load_take: assert property (@(posedge clk) disable iff (rst)
    loadNow |=> active == $past(pending))
    else $error("load event did not adopt pending setting");
  a_factor_calc: assert property (@(posedge clk) disable iff (rst)
    active.weightX == 4'h1 ##1 $stable(active) |-> factorX == {active.divisor, 3'h0})
    else $error("weight one factor not equal divisor");
  a_res_mirror: assert property (@(posedge clk) disable iff (rst)
    ##1 $stable(mirror) && $stable(active) && mirror
      |-> resShiftX == {4'h0, `PM_EXTRA} + {4'h0, shX})
    else $error("plane mirror shift wrong");
  a_sel_bad: assert property (@(posedge clk) disable iff (rst)
    !$onehot(active.weightY) ##1 $stable(active) |-> selBad)
    else $error("bad weight not flagged");

  // Load event steps: the trigger, then the pending setting is taken
  sequence s_manual_fall;
    manualPrev && !manualSw;
  endsequence
  sequence s_sys_rise;
    sysReset && !sysPrev;
  endsequence
  sequence s_adopted;
    ##1 active == $past(pending);
  endsequence

  a_manual_load: assert property (@(posedge clk) disable iff (rst)
    s_manual_fall |-> s_adopted)
    else $error("manual toggle did not adopt setting");
  a_sys_load: assert property (@(posedge clk) disable iff (rst)
    s_sys_rise |-> s_adopted)
    else $error("system reset did not adopt setting");
  a_reinit_load: assert property (@(posedge clk) disable iff (rst)
    reinitCmd |-> s_adopted)
    else $error("re-initialise did not adopt setting");
  a_factor_range: assert property (@(posedge clk) disable iff (rst)
    ##1 $stable(active) && $onehot(active.weightX) && active.divisor >= `DIV_MIN
      |-> factorX >= `FACT_MIN && factorX <= `FACT_MAX)
    else $error("factor outside one to fifteen");
  a_factor_w8: assert property (@(posedge clk) disable iff (rst)
    active.weightY == 4'h8 ##1 $stable(active) |-> factorY == {3'h0, active.divisor})
    else $error("weight eight factor wrong");
  a_div_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 $stable(active) |-> resDivX == {3'h0, active.divisor} && resDivY == resDivX)
    else $error("shared divisor not on both axes");
  a_res_linear: assert property (@(posedge clk) disable iff (rst)
    ##1 $stable(mirror) && $stable(active) && !mirror
      |-> resShiftY == {4'h0, `LIN_EXTRA} + {4'h0, shY})
    else $error("linear shift wrong");
  a_sel_good: assert property (@(posedge clk) disable iff (rst)
    $onehot(active.weightX) && $onehot(active.weightY) && active.divisor >= `DIV_MIN
      ##1 $stable(active) |-> !selBad)
    else $error("legal setting flagged bad");
  a_mirror_hold: assert property (@(posedge clk) disable iff (rst)
    $past(!rst) && !$past(apbWr && hitCtrl) |-> $stable(mirror))
    else $error("optics type changed without control write");
endmodule

/* test/switch_bank.sv */
`timescale 1ns/1ns
module switch_bank
  import res_ext_pkg::*;
(
  // Chosen positions
  input  wire logic [2:0] divIdx,
  input  wire logic [1:0] wxIdx,
  input  wire logic [1:0] wyIdx,
  // Switch levels
  output      ext_sel_t   sel
);
  // Index ranges keep the switches legal
  assign sel.divisor = 4'h8 + {1'h0, divIdx};
  assign sel.weightX = 4'h1 << wxIdx;
  assign sel.weightY = 4'h1 << wyIdx;
endmodule

/* test/resolution_extension_select_tb_top.sv */
`timescale 1ns/1ns
`include "res_ext_defines.svh"
module resolution_extension_select_tb_top
  import res_ext_pkg::*;
;
  logic        clk, rst, sysReset, selBad, err;
  apb_req_t    apbReq;
  apb_rsp_t    apbRsp;
  ext_sel_t    selIn;
  logic [6:0]  factorX, factorY, resShiftX, resShiftY, resDivX, resDivY;
  logic [2:0]  divIdx;
  logic [1:0]  wxIdx, wyIdx;
  logic [7:0]  rnd;
  logic [31:0] rd;
  int          error_cnt, n_compared, cyc, eDiv, eWx, eWy, eMir;

  switch_bank i_switch_bank (.divIdx(divIdx), .wxIdx(wxIdx), .wyIdx(wyIdx), .sel(selIn));
  resolution_extension_select i_resolution_extension_select (.clk(clk), .rst(rst),
    .selIn(selIn), .sysReset(sysReset), .apbReq(apbReq), .apbRsp(apbRsp),
    .factorX(factorX), .factorY(factorY), .resShiftX(resShiftX), .resShiftY(resShiftY),
    .resDivX(resDivX), .resDivY(resDivY), .selBad(selBad));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, a run needs about a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("mismatch t=%0t timeout", $time);
      end_of_test;
    end
  end

  task chk(input logic [6:0] got, input int exp);
    n_compared++;
    if (got !== 7'(exp)) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, got, 7'(exp));
    end
  endtask

  task chkWord(input logic [31:0] got, input int exp);
    n_compared++;
    if (got !== 32'(exp)) begin
      error_cnt++;
      $display("mismatch t=%0t word %h exp %h", $time, got, 32'(exp));
    end
  endtask

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task cmpAll;
    chk(factorX, eDiv * 8 / eWx);
    chk(factorY, eDiv * 8 / eWy);
    chk(resShiftX, eMir + 5 - $clog2(eWx));
    chk(resShiftY, eMir + 5 - $clog2(eWy));
    chk(resDivX, eDiv);
    chk(resDivY, eDiv);
    chk({6'h00, selBad}, 0);
  endtask

  // Three ways to adopt the pending switches
  task load(input int how, input int m);
    // Two load events per change, so transients settle
    repeat (2) begin
      case (how)
        0: begin
          @(posedge clk);
          sysReset <= 1'b1;
          @(posedge clk);
          sysReset <= 1'b0;
        end
        1: begin
          apb(1'b1, `OFF_CTRL, 32'(2 + 4 * m));
          apb(1'b1, `OFF_CTRL, 32'(4 * m));
        end
        default: apb(1'b1, `OFF_CTRL, 32'(1 + 4 * m));
      endcase
    end
    eDiv = 8 + divIdx;
    eWx = 1 << wxIdx;
    eWy = 1 << wyIdx;
    eMir = m;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    sysReset = 1'b0;
    apbReq = '0;
    divIdx = 3'h0;
    wxIdx = 2'h3;
    wyIdx = 2'h3;
    rnd = 8'h04;
    eDiv = 8;
    eWx = 8;
    eWy = 8;
    repeat (2) @(posedge clk);
    cmpAll;
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmpAll;
    load(0, 0);
    cmpAll;
    $display("reset test done");
    for (int i = 0; i < 30; i++) begin
      rnd = nx(rnd);
      divIdx <= rnd[2:0];
      wxIdx <= rnd[4:3];
      wyIdx <= rnd[6:5];
      repeat (3) @(posedge clk);
      cmpAll;
      apb(1'b1, `OFF_CTRL, 32'(4 * rnd[7]));
      load(i % 3, int'(rnd[7]));
      cmpAll;
      apb(1'b0, `OFF_FACT, 32'h0000_0000);
      chk(rd[13:7], eDiv * 8 / eWy);
      chk(rd[6:0], eDiv * 8 / eWx);
      apb(1'b0, `OFF_SEL, 32'h0000_0000);
      chkWord(rd, 4096 + eDiv * 256 + eWx * 16 + eWy);
      apb(1'b0, `OFF_ACT, 32'h0000_0000);
      chkWord(rd, eDiv * 256 + eWx * 16 + eWy);
      apb(1'b0, `OFF_RES, 32'h0000_0000);
      chkWord(rd, (eMir + 5 - $clog2(eWy)) * 128 + eMir + 5 - $clog2(eWx));
      apb(1'b0, `OFF_CTRL, 32'h0000_0000);
      chkWord(rd, 4 * eMir);
    end
    $display("load test done");
    apb(1'b0, 32'h0000_0040, 32'h0000_0000);
    chk({6'h00, err}, 1);
    chkWord(rd, 0);
    $display("unmapped test done");
    end_of_test;
  end
endmodule
